// File: rtl/optcfg_pkg.sv
package optcfg_pkg;

   // Option word layout.
   localparam int OPT_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [15:0] OPT_DEFAULT = 16'h0000;
   localparam int BIT_STOP_WD = 9;
   localparam int BIT_LVD = 8;
   localparam int BIT_PROTECT = 7;
   localparam int BIT_OSC_RC = 6;
   localparam int BIT_CLEAR5 = 5;
   localparam int BIT_SET4 = 4;
   localparam int BIT_NMI_PULL = 3;
   localparam int BIT_TIMER_PIN_PULLUP_EN = 2;
   localparam int BIT_HW_WDG = 1;
   localparam int BIT_OSG = 0;
   // High byte bits 15:10 must stay clear.
   localparam logic [7:0] MSB_CLEAR_MASK = 8'hFC;

   // Programmer port map.
   localparam int PORT_AW = 2;
   localparam logic [1:0] PORT_LSB = 2'h0;
   localparam logic [1:0] PORT_MSB = 2'h1;
   localparam logic [1:0] PORT_STATUS = 2'h2;
   localparam int STAT_MODE = 0;
   localparam int STAT_BURN_LSB = 1;
   localparam int STAT_BURN_MSB = 2;
   localparam int STAT_FMT_ERR = 3;
   localparam int STAT_MASKED = 4;

   // Programming level on the supply pin, in millivolts.
   localparam int VPP_PROG_MV = 12500;

   // Program space map.
   localparam int PADDR_W = 12;
   localparam logic [11:0] USER_START_SMALL = 12'hBA0;
   localparam logic [11:0] USER_START_MID = 12'h880;
   localparam logic [11:0] USER_START_LARGE = 12'h080;
   localparam logic [11:0] USER_END = 12'hF9F;
   localparam logic [11:0] IRQ_VEC_START = 12'hFF0;
   localparam logic [11:0] IRQ_VEC_END = 12'hFF7;
   localparam logic [11:0] NMI_VEC_START = 12'hFFC;
   localparam logic [11:0] NMI_VEC_END = 12'hFFD;
   localparam logic [11:0] RST_VEC_START = 12'hFFE;
   localparam int VARIANT_SMALL = 0;
   localparam int VARIANT_MID = 1;
   localparam int VARIANT_LARGE = 2;

   typedef enum logic [2:0] {
      REGION_RESERVED,
      REGION_USER,
      REGION_IRQ_VEC,
      REGION_NMI_VEC,
      REGION_RESET_VEC
   } region_t;

   typedef enum logic [1:0] {
      LOAD_CFG,
      RUN_CFG,
      PROG_CFG
   } cfg_state_t;

endpackage : optcfg_pkg

// File: rtl/opt_store_if.sv
interface opt_store_if;
   logic wr_lsb;
   logic wr_msb;
   logic [7:0] wr_data;
   logic [15:0] stored;
   logic [1:0] burned;

   modport store (input wr_lsb, input wr_msb, input wr_data, output stored, output burned);
   modport ctrl (output wr_lsb, output wr_msb, output wr_data, input stored, input burned);
endinterface : opt_store_if

// File: rtl/option_fuse_store.sv
module option_fuse_store #(
   parameter bit MASKED = 1'b0,
   parameter logic [15:0] MASK_CODE = 16'h0010
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Store side.
   opt_store_if.store st
);

   // A byte takes one write only; later writes leave it untouched.
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st.stored <= MASKED ? MASK_CODE : optcfg_pkg::OPT_DEFAULT;
         st.burned <= MASKED ? 2'h3 : 2'h0;
      end
      else
      begin
         if (st.wr_lsb && !st.burned[0])
         begin
            st.stored[7:0] <= st.wr_data;
            st.burned[0] <= 1'b1;
         end
         if (st.wr_msb && !st.burned[1])
         begin
            st.stored[15:8] <= st.wr_data;
            st.burned[1] <= 1'b1;
         end
      end
   end

   a_byte_once:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      st.burned[0] |=> $stable(st.stored[7:0]) && st.burned[0])
   else $error("programmed low option byte changed");

   a_fresh_default:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (!MASKED && !st.burned[1]) |-> st.stored[15:8] == 8'h00)
   else $error("unprogrammed high option byte not zero");

endmodule : option_fuse_store

// File: rtl/option_byte_config.sv
module option_byte_config #(
   parameter int MEM_VARIANT = optcfg_pkg::VARIANT_LARGE,
   parameter bit MASKED = 1'b0,
   parameter logic [15:0] MASK_CODE = 16'h0010
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Pins.
   input wire logic vpp_high_in,
   input wire logic nmi_pin_in,
   // Programmer port.
   input wire logic [1:0] prog_addr_in,
   input wire logic [7:0] prog_wdata_in,
   input wire logic prog_wr_in,
   input wire logic prog_rd_in,
   output logic [7:0] prog_rdata_out,
   // Core side.
   input wire logic watchdog_active_in,
   input wire logic [11:0] cpu_prog_addr_in,
   output logic [2:0] prog_region_out,
   output logic stop_permit_out,
   output logic prog_mode_out,
   // Configuration.
   output logic stop_with_watchdog_ctrl_out,
   output logic low_voltage_detect_en_out,
   output logic readout_protect_out,
   output logic osc_rc_sel_out,
   output logic nmi_pin_pullup_en_out,
   output logic timer_pin_pullup_en_out,
   output logic hardware_watchdog_sel_out,
   output logic osc_safeguard_en_out
);

   localparam logic [11:0] USER_START =
      (MEM_VARIANT == optcfg_pkg::VARIANT_SMALL) ? optcfg_pkg::USER_START_SMALL :
      (MEM_VARIANT == optcfg_pkg::VARIANT_MID) ? optcfg_pkg::USER_START_MID :
      optcfg_pkg::USER_START_LARGE;

   opt_store_if st_if ();

   logic [2:0] vpp_sync;
   logic [2:0] nmi_sync;
   logic prog_mode;
   logic nmi_level;
   logic fmt_err;
   logic [15:0] cfg;
   optcfg_pkg::cfg_state_t state;
   optcfg_pkg::cfg_state_t next_state;

   option_fuse_store #(
      .MASKED(MASKED),
      .MASK_CODE(MASK_CODE)
   ) u_store (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .st(st_if.store)
   );

   // Pins pass three flops; a level counts once the last two agree.
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         vpp_sync <= 3'h0;
         nmi_sync <= 3'h0;
         prog_mode <= 1'b0;
         nmi_level <= 1'b0;
      end
      else
      begin
         vpp_sync <= {vpp_sync[1:0], vpp_high_in};
         nmi_sync <= {nmi_sync[1:0], nmi_pin_in};
         if (vpp_sync[1] == vpp_sync[2])
         begin
            prog_mode <= vpp_sync[2];
         end
         if (nmi_sync[1] == nmi_sync[2])
         begin
            nmi_level <= nmi_sync[2];
         end
      end
   end

   // Write decode.
   wire sel_lsb = prog_addr_in == optcfg_pkg::PORT_LSB;
   wire sel_msb = prog_addr_in == optcfg_pkg::PORT_MSB;
   wire sel_stat = prog_addr_in == optcfg_pkg::PORT_STATUS;
   wire wr_ok = prog_wr_in && prog_mode && !MASKED;
   wire lsb_fmt_ok = !prog_wdata_in[optcfg_pkg::BIT_CLEAR5]
      && prog_wdata_in[optcfg_pkg::BIT_SET4];
   wire msb_fmt_ok = (prog_wdata_in & optcfg_pkg::MSB_CLEAR_MASK) == 8'h00;
   wire bad_fmt = wr_ok && ((sel_lsb && !lsb_fmt_ok) || (sel_msb && !msb_fmt_ok));

   assign st_if.wr_lsb = wr_ok && sel_lsb && lsb_fmt_ok;
   assign st_if.wr_msb = wr_ok && sel_msb && msb_fmt_ok;
   assign st_if.wr_data = prog_wdata_in;

   // Read decode: nothing is visible outside programming mode.
   wire [7:0] status_word = {3'h0, MASKED, fmt_err, st_if.burned, prog_mode};
   wire [7:0] opt_word = MASKED ? 8'h00 :
      (sel_lsb ? st_if.stored[7:0] : st_if.stored[15:8]);
   wire [7:0] next_rdata = !(prog_rd_in && prog_mode) ? 8'h00 :
      (sel_stat ? status_word : ((sel_lsb || sel_msb) ? opt_word : 8'h00));

   // Program space decode.
   wire in_user = cpu_prog_addr_in >= USER_START && cpu_prog_addr_in <= optcfg_pkg::USER_END;
   wire in_irq = cpu_prog_addr_in >= optcfg_pkg::IRQ_VEC_START
      && cpu_prog_addr_in <= optcfg_pkg::IRQ_VEC_END;
   wire in_nmi = cpu_prog_addr_in >= optcfg_pkg::NMI_VEC_START
      && cpu_prog_addr_in <= optcfg_pkg::NMI_VEC_END;
   wire in_rst = cpu_prog_addr_in >= optcfg_pkg::RST_VEC_START;
   wire [2:0] next_region =
      in_user ? 3'(optcfg_pkg::REGION_USER) :
      in_irq ? 3'(optcfg_pkg::REGION_IRQ_VEC) :
      in_nmi ? 3'(optcfg_pkg::REGION_NMI_VEC) :
      in_rst ? 3'(optcfg_pkg::REGION_RESET_VEC) :
      3'(optcfg_pkg::REGION_RESERVED);

   // Stop is refused with the watchdog running unless the option and NMI allow it.
   wire next_stop_permit = !watchdog_active_in
      || (cfg[optcfg_pkg::BIT_STOP_WD] && nmi_level);

   // Settings load once after reset and again on leaving programming mode.
   always_comb
   begin
      case (state)
         optcfg_pkg::LOAD_CFG: next_state = prog_mode ? optcfg_pkg::PROG_CFG
            : optcfg_pkg::RUN_CFG;
         optcfg_pkg::RUN_CFG: next_state = prog_mode ? optcfg_pkg::PROG_CFG
            : optcfg_pkg::RUN_CFG;
         optcfg_pkg::PROG_CFG: next_state = prog_mode ? optcfg_pkg::PROG_CFG
            : optcfg_pkg::LOAD_CFG;
         default: next_state = optcfg_pkg::LOAD_CFG;
      endcase
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state <= optcfg_pkg::LOAD_CFG;
         cfg <= optcfg_pkg::OPT_DEFAULT;
      end
      else
      begin
         state <= next_state;
         if (state == optcfg_pkg::LOAD_CFG)
         begin
            cfg <= st_if.stored;
         end
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         prog_rdata_out <= 8'h00;
         prog_region_out <= 3'(optcfg_pkg::REGION_RESERVED);
         stop_permit_out <= 1'b0;
         fmt_err <= 1'b0;
      end
      else
      begin
         prog_rdata_out <= next_rdata;
         prog_region_out <= next_region;
         stop_permit_out <= next_stop_permit;
         fmt_err <= fmt_err || bad_fmt;
      end
   end

   assign prog_mode_out = prog_mode;
   assign stop_with_watchdog_ctrl_out = cfg[optcfg_pkg::BIT_STOP_WD];
   assign low_voltage_detect_en_out = cfg[optcfg_pkg::BIT_LVD];
   assign readout_protect_out = cfg[optcfg_pkg::BIT_PROTECT];
   assign osc_rc_sel_out = cfg[optcfg_pkg::BIT_OSC_RC];
   assign nmi_pin_pullup_en_out = cfg[optcfg_pkg::BIT_NMI_PULL];
   assign timer_pin_pullup_en_out = cfg[optcfg_pkg::BIT_TIMER_PIN_PULLUP_EN];
   assign hardware_watchdog_sel_out = cfg[optcfg_pkg::BIT_HW_WDG];
   assign osc_safeguard_en_out = cfg[optcfg_pkg::BIT_OSG];

   // The filtered mode flag lags the pin by four edges, so writes are tied to the flag alone.
   a_write_needs_vpp:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (st_if.wr_lsb || st_if.wr_msb) |-> prog_mode)
   else $error("option write outside programming mode");

   a_mode_follows_pin:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      $rose(prog_mode)
      |-> $past(vpp_sync[2]) && $past(vpp_sync[1]))
   else $error("programming mode entered without the supply level");

   a_no_read_run:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !prog_mode |=> prog_rdata_out == 8'h00)
   else $error("option data visible outside programming mode");

   a_masked_hidden:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (MASKED && prog_rd_in && !sel_stat) |=> prog_rdata_out == 8'h00)
   else $error("mask part returned option byte");

   a_format_refused:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      bad_fmt |=> fmt_err && $stable(st_if.stored))
   else $error("malformed option write not refused");

   a_stop_permit:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (watchdog_active_in && !cfg[optcfg_pkg::BIT_STOP_WD]) |=> !stop_permit_out)
   else $error("stop permitted with watchdog active");

   a_cfg_stable:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (state == optcfg_pkg::RUN_CFG) ##1 (state == optcfg_pkg::RUN_CFG) |-> $stable(cfg))
   else $error("configuration changed while running");

   a_reset_vector:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      cpu_prog_addr_in == 12'hFFF |=> prog_region_out == 3'(optcfg_pkg::REGION_RESET_VEC))
   else $error("reset vector not decoded");

   a_user_bounds:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cpu_prog_addr_in < USER_START || cpu_prog_addr_in == 12'hFA0)
      |=> prog_region_out == 3'(optcfg_pkg::REGION_RESERVED))
   else $error("reserved address decoded as used");

   a_high_byte_once:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      st_if.burned[1]
      |=> $stable(st_if.stored[15:8]) && st_if.burned[1])
   else $error("programmed high option byte changed");

   a_mask_store_fixed:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      MASKED
      |=> $stable(st_if.stored))
   else $error("mask part option code changed");

   a_fmt_sticky:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      fmt_err
      |=> fmt_err)
   else $error("format error flag cleared while running");

   a_rdata_idle:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      !prog_rd_in
      |=> prog_rdata_out == 8'h00)
   else $error("read data shown without a read strobe");

   a_cfg_loaded:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      state == optcfg_pkg::LOAD_CFG
      |=> cfg == $past(st_if.stored))
   else $error("configuration not loaded from the option store");

   a_stop_granted:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (!watchdog_active_in || (cfg[optcfg_pkg::BIT_STOP_WD] && nmi_level))
      |=> stop_permit_out)
   else $error("stop refused although allowed");

   a_irq_vectors:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cpu_prog_addr_in >= optcfg_pkg::IRQ_VEC_START && cpu_prog_addr_in <= optcfg_pkg::IRQ_VEC_END)
      |=> prog_region_out == 3'(optcfg_pkg::REGION_IRQ_VEC))
   else $error("interrupt vector not decoded");

   a_nmi_vector:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cpu_prog_addr_in >= optcfg_pkg::NMI_VEC_START && cpu_prog_addr_in <= optcfg_pkg::NMI_VEC_END)
      |=> prog_region_out == 3'(optcfg_pkg::REGION_NMI_VEC))
   else $error("nmi vector not decoded");

   a_vec_reserved:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      ((cpu_prog_addr_in > optcfg_pkg::USER_END && cpu_prog_addr_in < optcfg_pkg::IRQ_VEC_START)
      || (cpu_prog_addr_in > optcfg_pkg::IRQ_VEC_END && cpu_prog_addr_in < optcfg_pkg::NMI_VEC_START))
      |=> prog_region_out == 3'(optcfg_pkg::REGION_RESERVED))
   else $error("reserved vector area decoded as used");

   a_user_region:
   assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (cpu_prog_addr_in >= USER_START && cpu_prog_addr_in <= optcfg_pkg::USER_END)
      |=> prog_region_out == 3'(optcfg_pkg::REGION_USER))
   else $error("user memory not decoded");

endmodule : option_byte_config

// File: tb/opt_programmer.sv
module opt_programmer (
   // Clock.
   input wire logic clock_in,
   // Programmer pins.
   output logic vpp_high_out,
   output logic [1:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire logic [7:0] rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      vpp_high_out = 1'b0;
      addr_out = 2'h0;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   task supply(input logic level);
      @(posedge clock_in);
      vpp_high_out <= level;
   endtask : supply

   // The data lines are not held once the strobe is gone, so they flip.
   task write_raw(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clock_in);
      wr_out <= 1'b0;
      wdata_out <= ~d;
   endtask : write_raw

   task write_option(input logic [7:0] lo, input logic [7:0] hi);
      write_raw(2'h0, {lo[7:6], 2'b01, lo[3:0]});
      write_raw(2'h1, {6'h00, hi[1:0]});
   endtask : write_option

   task read_byte(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clock_in);
      rd_out <= 1'b0;
      @(negedge clock_in);
      d = rdata_in;
   endtask : read_byte

endmodule : opt_programmer

// File: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic nmi_pin_in = 1'b0;
   logic watchdog_active_in = 1'b0;
   logic [11:0] cpu_prog_addr_in = 12'h000;
   logic vpp, wr, rd;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [2:0] region;
   logic stop_permit, prog_mode;
   wire logic [7:0] cfg;
   wire logic [7:0] cfg_m;
   wire logic [7:0] rdata_m;
   int bad_count = 0;
   int n_checks = 0;
   logic [11:0] addrs [10] = '{12'h07F, 12'h080, 12'hF9F, 12'hFA0, 12'hFEF,
                               12'hFF0, 12'hFF7, 12'hFF8, 12'hFFC, 12'hFFF};
   logic [2:0] codes [10] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0, 3'h3, 3'h4};

   always #20 clock_in = ~clock_in;

   opt_programmer prog (.clock_in(clock_in), .vpp_high_out(vpp), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

   option_byte_config #(.MEM_VARIANT(optcfg_pkg::VARIANT_LARGE)) uut (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .vpp_high_in(vpp),
      .nmi_pin_in(nmi_pin_in), .prog_addr_in(addr), .prog_wdata_in(wdata),
      .prog_wr_in(wr), .prog_rd_in(rd), .prog_rdata_out(rdata),
      .watchdog_active_in(watchdog_active_in), .cpu_prog_addr_in(cpu_prog_addr_in),
      .prog_region_out(region), .stop_permit_out(stop_permit), .prog_mode_out(prog_mode),
      .stop_with_watchdog_ctrl_out(cfg[7]), .low_voltage_detect_en_out(cfg[6]),
      .readout_protect_out(cfg[5]), .osc_rc_sel_out(cfg[4]),
      .nmi_pin_pullup_en_out(cfg[3]), .timer_pin_pullup_en_out(cfg[2]),
      .hardware_watchdog_sel_out(cfg[1]), .osc_safeguard_en_out(cfg[0]));

   // Mask part beside the user part; its option code keeps the write format (bit 5 clear, bit 4 set, bits 15:10 clear).
   option_byte_config #(.MEM_VARIANT(optcfg_pkg::VARIANT_LARGE), .MASKED(1'b1),
      .MASK_CODE(16'h02D5)) uut_masked (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .vpp_high_in(vpp),
      .nmi_pin_in(nmi_pin_in), .prog_addr_in(addr), .prog_wdata_in(wdata),
      .prog_wr_in(wr), .prog_rd_in(rd), .prog_rdata_out(rdata_m),
      .watchdog_active_in(watchdog_active_in), .cpu_prog_addr_in(cpu_prog_addr_in),
      .prog_region_out(), .stop_permit_out(), .prog_mode_out(),
      .stop_with_watchdog_ctrl_out(cfg_m[7]), .low_voltage_detect_en_out(cfg_m[6]),
      .readout_protect_out(cfg_m[5]), .osc_rc_sel_out(cfg_m[4]),
      .nmi_pin_pullup_en_out(cfg_m[3]), .timer_pin_pullup_en_out(cfg_m[2]),
      .hardware_watchdog_sel_out(cfg_m[1]), .osc_safeguard_en_out(cfg_m[0]));

   task summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task wait_mode(input logic v);
      int i;
      for (i = 0; i < 30; i++)
      begin
         @(negedge clock_in);
         if (prog_mode === v)
            return;
      end
      bad_count++;
      $display("Error at %0t: programming mode did not follow the supply pin", $time);
      summarize();
   endtask : wait_mode

   initial
   begin
      #200000;
      bad_count++;
      $display("Error at %0t: run did not end in time", $time);
      summarize();
   end

   initial
   begin
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      watchdog_active_in <= 1'b1;
      nmi_pin_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      @(negedge clock_in);
      check(cfg, 8'h00);
      check(cfg_m, 8'hB5);
      check({7'h00, stop_permit}, 8'h00);
      prog.read_byte(optcfg_pkg::PORT_STATUS, d);
      check(d, 8'h00);
      prog.write_raw(optcfg_pkg::PORT_LSB, 8'hDF);
      $display("test fresh part done");

      prog.supply(1'b1);
      wait_mode(1'b1);
      prog.read_byte(optcfg_pkg::PORT_LSB, d);
      check(d, 8'h00);
      prog.write_raw(optcfg_pkg::PORT_LSB, 8'h8F);
      prog.read_byte(optcfg_pkg::PORT_STATUS, d);
      check(d, 8'h09);
      check(rdata_m, 8'h17);
      prog.write_raw(optcfg_pkg::PORT_MSB, 8'h07);
      prog.read_byte(optcfg_pkg::PORT_MSB, d);
      check(d, 8'h00);
      prog.write_option(8'hCF, 8'h03);
      prog.read_byte(optcfg_pkg::PORT_LSB, d);
      check(d, 8'hDF);
      check(rdata_m, 8'h00);
      prog.write_raw(optcfg_pkg::PORT_LSB, 8'h10);
      prog.write_raw(optcfg_pkg::PORT_MSB, 8'h00);
      prog.read_byte(optcfg_pkg::PORT_LSB, d);
      check(d, 8'hDF);
      prog.read_byte(optcfg_pkg::PORT_MSB, d);
      check(d, 8'h03);
      prog.read_byte(optcfg_pkg::PORT_STATUS, d);
      check(d, 8'h0F);
      $display("test programming done");

      prog.supply(1'b0);
      wait_mode(1'b0);
      repeat (3) @(negedge clock_in);
      check(cfg, 8'hFF);
      check(cfg_m, 8'hB5);
      repeat (3) @(negedge clock_in);
      check({7'h00, stop_permit}, 8'h01);
      @(posedge clock_in);
      nmi_pin_in <= 1'b0;
      repeat (6) @(negedge clock_in);
      check({7'h00, stop_permit}, 8'h00);
      @(posedge clock_in);
      watchdog_active_in <= 1'b0;
      repeat (3) @(negedge clock_in);
      check({7'h00, stop_permit}, 8'h01);
      prog.read_byte(optcfg_pkg::PORT_LSB, d);
      check(d, 8'h00);
      check(cfg, 8'hFF);
      check(cfg_m, 8'hB5);
      $display("test running configuration done");

      foreach (addrs[i])
      begin
         @(posedge clock_in);
         cpu_prog_addr_in <= addrs[i];
         @(posedge clock_in);
         @(negedge clock_in);
         check({5'h00, region}, {5'h00, codes[i]});
      end
      $display("test program map done");
      summarize();
   end

endmodule : testbench
